// ### core/period_timer.sv
// period timer with prescaler, period compare and postscaler, apb slave
// assumes pclk is the instruction clock and presetn covers all resets
//
// Overview of operation
// - writing the count register clears prescaler and postscaler counters.
// - writing the control register clears prescaler and postscaler counters.
// - any device reset clears the prescaler and postscaler counters.
// - a control register write leaves the count value unchanged.
// - the match pulse before the postscaler goes to the serial port.
// - postscale field bits 6..3 divides matches by field plus one.
// - control bit 7 reads zero and ignores writes.
// - reset loads control 0, count 0, period ff.
// - control at 12h, count at 11h, period at 92h.
// - count advances per tick and wraps to 0 after equalling period.
// - postscaler reaching its count sets the timer match flag, bit 1.
// - run bit, control bit 2, enables counting.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "period_timer_regs.svh"
module period_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic serial_shift_tick,
	output logic timer_match_flag,
	output logic timer_match_pending
);
	import period_timer_pkg::*;

	// ******************************************************************
	// bus decode
	// ******************************************************************
	logic access;
	logic wr;
	logic hit_count;
	logic hit_control;
	logic hit_period;
	logic hit_flags;
	logic hit_enables;
	logic hit_master;
	logic mapped;

	assign access = psel && penable;
	assign wr = access && pwrite;
	assign hit_count = paddr == {2'b00, `IDX_TIMER_COUNT, 2'b00};
	assign hit_control = paddr == {2'b00, `IDX_TIMER_CONTROL, 2'b00};
	assign hit_period = paddr == {2'b00, `IDX_TIMER_PERIOD, 2'b00};
	assign hit_flags = paddr == {2'b00, `IDX_PERIPHERAL_INTERRUPT_FLAGS, 2'b00};
	assign hit_enables =
		paddr == {2'b00, `IDX_PERIPHERAL_INTERRUPT_ENABLES, 2'b00};
	assign hit_master = paddr == {2'b00, `IDX_INTERRUPT_MASTER_CONTROL, 2'b00};
	assign mapped = hit_count || hit_control || hit_period || hit_flags ||
		hit_enables || hit_master;
	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	// ******************************************************************
	// registers
	// ******************************************************************
	logic [6:0] timer_control;
	logic [7:0] timer_count;
	logic [7:0] timer_period;
	logic [7:0] peripheral_interrupt_flags;
	logic [7:0] peripheral_interrupt_enables;
	logic [7:0] interrupt_master_control;
	logic scaler_clear;
	logic run;
	logic tick;
	logic match;
	logic post_done;
	logic [3:0] post_count;
	prescale_t pre_mode;

	assign scaler_clear = wr && (hit_count || hit_control);
	assign run = timer_control[`RUN_BIT];
	assign pre_mode = timer_control[`PRE_MSB] ? pre_div16 :
		(timer_control[`PRE_LSB] ? pre_div4 : pre_div1);

	// bit 7 is not stored at all
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control <= `RST_TIMER_CONTROL;
		end else if (wr && hit_control) begin
			timer_control <= pwdata[6:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_period <= `RST_TIMER_PERIOD;
		end else if (wr && hit_period) begin
			timer_period <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			peripheral_interrupt_enables <= `RST_FLAGS;
			interrupt_master_control <= `RST_FLAGS;
		end else if (wr && hit_enables) begin
			peripheral_interrupt_enables <= pwdata[7:0];
		end else if (wr && hit_master) begin
			interrupt_master_control <= pwdata[7:0];
		end
	end

	// ******************************************************************
	// prescaler and counter
	// ******************************************************************
	prescale_counter prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.clear(scaler_clear),
		.run(run),
		.mode(pre_mode),
		.tick(tick)
	);

	assign match = tick && (timer_count == timer_period);

	// control writes do not touch the count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_count <= `RST_TIMER_COUNT;
		end else if (wr && hit_count) begin
			timer_count <= pwdata[7:0];
		end else if (match) begin
			timer_count <= `RST_TIMER_COUNT;
		end else if (tick) begin
			timer_count <= timer_count + 8'h01;
		end
	end

	// ******************************************************************
	// postscaler and flag
	// ******************************************************************
	assign post_done = match &&
		(post_count == timer_control[`POST_MSB:`POST_LSB]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			post_count <= 4'h0;
		end else if (scaler_clear) begin
			post_count <= 4'h0;
		end else if (post_done) begin
			post_count <= 4'h0;
		end else if (match) begin
			post_count <= post_count + 4'h1;
		end
	end

	// set wins over a software clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			peripheral_interrupt_flags <= `RST_FLAGS;
		end else begin
			if (wr && hit_flags) begin
				peripheral_interrupt_flags <= pwdata[7:0];
			end
			if (post_done) begin
				peripheral_interrupt_flags[`FLAG_BIT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_shift_tick <= 1'b0;
		end else begin
			serial_shift_tick <= match;
		end
	end

	assign timer_match_flag = peripheral_interrupt_flags[`FLAG_BIT];
	assign timer_match_pending = timer_match_flag &&
		peripheral_interrupt_enables[`FLAG_BIT];

	// ******************************************************************
	// read data
	// ******************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			if (hit_count) begin
				prdata <= {24'h0, timer_count};
			end else if (hit_control) begin
				prdata <= {25'h0, timer_control};
			end else if (hit_period) begin
				prdata <= {24'h0, timer_period};
			end else if (hit_flags) begin
				prdata <= {24'h0, peripheral_interrupt_flags};
			end else if (hit_enables) begin
				prdata <= {24'h0, peripheral_interrupt_enables};
			end else if (hit_master) begin
				prdata <= {24'h0, interrupt_master_control};
			end else begin
				prdata <= 32'h0;
			end
		end
	end
endmodule : period_timer

// ### core/period_timer_regs.svh
// register offsets, field positions and reset values of the period timer
// assumes byte addresses on an apb bus, four times the printed index
`ifndef PERIOD_TIMER_REGS_SVH
`define PERIOD_TIMER_REGS_SVH

`define IDX_INTERRUPT_MASTER_CONTROL 8'h0b
`define IDX_PERIPHERAL_INTERRUPT_FLAGS 8'h0c
`define IDX_TIMER_COUNT 8'h11
`define IDX_TIMER_CONTROL 8'h12
`define IDX_PERIPHERAL_INTERRUPT_ENABLES 8'h8c
`define IDX_TIMER_PERIOD 8'h92

`define RST_TIMER_COUNT 8'h00
`define RST_TIMER_CONTROL 7'h00
`define RST_TIMER_PERIOD 8'hff
`define RST_FLAGS 8'h00

`define POST_MSB 6
`define POST_LSB 3
`define RUN_BIT 2
`define PRE_MSB 1
`define PRE_LSB 0
`define FLAG_BIT 1

`define PRE_DIV4_LAST 4'h3
`define PRE_DIV16_LAST 4'hf

`endif

// ### core/period_timer_pkg.sv
// types shared by the period timer files
// assumes the register header is included by the users of the offsets
package period_timer_pkg;
	typedef enum logic [1:0] {
		pre_div1,
		pre_div4,
		pre_div16
	} prescale_t;
endpackage : period_timer_pkg

// ### core/prescale_counter.sv
// prescaler: turns the run enable into a tick at 1, 1/4 or 1/16 rate
// assumes one clock, pclk, and a synchronous clear from the owner
`timescale 1ns/1ps
`include "period_timer_regs.svh"
module prescale_counter (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire logic run,
	input wire period_timer_pkg::prescale_t mode,
	output logic tick
);
	import period_timer_pkg::*;

	logic [3:0] count;
	logic [3:0] last;

	always_comb begin
		unique case (mode)
			pre_div1: last = 4'h0;
			pre_div4: last = `PRE_DIV4_LAST;
			pre_div16: last = `PRE_DIV16_LAST;
			default: last = `PRE_DIV16_LAST;
		endcase
	end

	assign tick = run && (count == last);

	// holds while stopped, cleared by count or control register writes and reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 4'h0;
		end else if (clear) begin
			count <= 4'h0;
		end else if (tick) begin
			count <= 4'h0;
		end else if (run) begin
			count <= count + 4'h1;
		end
	end
endmodule : prescale_counter

// ### testbench/period_timer_checker.sv
// port assertions for the period timer
// assumes a bind onto period_timer and the single clock pclk
`timescale 1ns/1ps
`include "period_timer_regs.svh"
module period_timer_checker (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	input logic serial_shift_tick,
	input logic timer_match_flag,
	input logic timer_match_pending
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire rd = acc && !pwrite;
	wire [7:0] idx = paddr[9:2];
	wire mapped = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0 &&
		idx inside {`IDX_INTERRUPT_MASTER_CONTROL,
		`IDX_PERIPHERAL_INTERRUPT_FLAGS, `IDX_TIMER_COUNT,
		`IDX_TIMER_CONTROL, `IDX_PERIPHERAL_INTERRUPT_ENABLES,
		`IDX_TIMER_PERIOD};
	wire wctl = acc && pwrite && mapped && idx == `IDX_TIMER_CONTROL;
	wire wflg = acc && pwrite && mapped &&
		idx == `IDX_PERIPHERAL_INTERRUPT_FLAGS;
	AST_READY: assert property (acc |-> pready)
		else $error("no ready");
	AST_ERR: assert property (acc |-> pslverr == !mapped)
		else $error("bad pslverr");
	AST_UNMAPPED: assert property (rd && !mapped |-> prdata == 0)
		else $error("unmapped read not zero");
	AST_UPPER: assert property (rd |-> prdata[31:8] == 0)
		else $error("upper read bits set");
	AST_BIT7: assert property
		(rd && mapped && idx == `IDX_TIMER_CONTROL |-> !prdata[7])
		else $error("control bit 7 reads one");
	AST_PEND: assert property
		(timer_match_pending |-> timer_match_flag)
		else $error("pending without flag");
	AST_FLAG: assert property
		($rose(timer_match_flag) |-> serial_shift_tick || $past(wflg))
		else $error("flag rose without match");
	AST_STOP: assert property
		(wctl && !pwdata[`RUN_BIT] |-> ##2 !serial_shift_tick)
		else $error("tick after stop");
endmodule : period_timer_checker

// ### testbench/period_timer_test.sv
// self-checking test of the period timer over apb
// assumes the checker is compiled first and bound below
`timescale 1ns/1ps
`include "period_timer_regs.svh"
module period_timer_test;
	logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, err, tick, flag, pend;
	int n_errors = 0, checks_done = 0, cyc = 0, n;
	localparam logic [11:0] A_CNT = {2'h0, `IDX_TIMER_COUNT, 2'h0};
	localparam logic [11:0] A_CTL = {2'h0, `IDX_TIMER_CONTROL, 2'h0};
	localparam logic [11:0] A_PER = {2'h0, `IDX_TIMER_PERIOD, 2'h0};
	localparam logic [11:0] A_FLG = {2'h0, `IDX_PERIPHERAL_INTERRUPT_FLAGS, 2'h0};
	localparam logic [11:0] A_ENA = {2'h0, `IDX_PERIPHERAL_INTERRUPT_ENABLES, 2'h0};
	period_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_shift_tick(tick), .timer_match_flag(flag),
		.timer_match_pending(pend));
	initial forever #10 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			complete_run();
		end
	end
	task complete_run;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : xfer
	task do_reset;
		@(posedge pclk);
		presetn <= 1'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
	endtask : do_reset
	task t_reset;
		logic [11:0] a[4] = '{A_CNT, A_CTL, A_PER, A_FLG};
		logic [7:0] e[4] = '{`RST_TIMER_COUNT, 8'h00, `RST_TIMER_PERIOD, `RST_FLAGS};
		for (int i = 0; i < 4; i++) begin
			xfer(1'h0, a[i], 32'h0);
			chk(rd, {24'h0, e[i]});
		end
		xfer(1'h0, 12'h004, 32'h0);
		chk({rd[30:0], err}, 32'h1);
	endtask : t_reset
	task t_hold;
		xfer(1'h1, A_CTL, 32'hf8);
		xfer(1'h1, A_CNT, 32'h33);
		xfer(1'h1, A_PER, 32'h5a);
		repeat (20) @(posedge pclk);
		xfer(1'h1, A_CTL, 32'hf8);
		xfer(1'h0, A_CNT, 32'h0);
		chk(rd, 32'h33);
		xfer(1'h0, A_PER, 32'h0);
		chk(rd, 32'h5a);
		xfer(1'h0, A_CTL, 32'h0);
		chk(rd, 32'h78);
	endtask : t_hold
	task wait_tick;
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (tick !== 1'h1 && n < 100);
	endtask : wait_tick
	task t_rates;
		int d[4] = '{1, 4, 16, 16};
		xfer(1'h1, A_PER, 32'h2);
		xfer(1'h1, A_CNT, 32'h0);
		for (int p = 0; p < 4; p++) begin
			xfer(1'h1, A_CTL, 32'h4 | p);
			wait_tick;
			wait_tick;
			chk(n, 3 * d[p]);
		end
	endtask : t_rates
	task t_post;
		int f[3] = '{0, 2, 15};
		xfer(1'h1, A_PER, 32'h1);
		xfer(1'h1, A_CNT, 32'h0);
		for (int i = 0; i < 3; i++) begin
			xfer(1'h1, A_CTL, 32'h0);
			xfer(1'h1, A_FLG, 32'h0);
			xfer(1'h1, A_CTL, 32'h4 | (f[i] << 3));
			n = 0;
			do begin
				@(posedge pclk);
				#1;
				if (tick === 1'h1) n++;
			end while (flag !== 1'h1 && n < 40);
			chk(n, f[i] + 1);
		end
		chk(pend, 32'h0);
		xfer(1'h1, A_ENA, 32'h2);
		#1;
		chk(pend, 32'h1);
	endtask : t_post
	task t_clear;
		logic [11:0] a[2] = '{A_CNT, A_CTL};
		for (int i = 0; i < 2; i++) begin
			xfer(1'h1, A_PER, 32'hff);
			xfer(1'h1, A_CTL, 32'h6);
			xfer(1'h1, A_CNT, 32'h40);
			repeat (10) @(posedge pclk);
			xfer(1'h1, a[i], i ? 32'h6 : 32'h40);
			repeat (10) @(posedge pclk);
			xfer(1'h0, A_CNT, 32'h0);
			chk(rd, 32'h40);
		end
	endtask : t_clear
	initial begin
		do_reset;
		t_reset;
		t_hold;
		t_rates;
		t_post;
		t_clear;
		do_reset;
		t_reset;
		complete_run;
	end
endmodule : period_timer_test
bind period_timer period_timer_checker chk_u (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .serial_shift_tick(serial_shift_tick),
	.timer_match_flag(timer_match_flag),
	.timer_match_pending(timer_match_pending));
